// *** inc/adc_monitor_pkg.sv ***
package adc_monitor_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SAMPLE_NS = 3840;
  localparam int SAMPLE_CYC = (T_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_VOUT_US = 200;
  localparam int VOUT_CYC = T_VOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int T_SUP_MS = 2;
  localparam int SUP_CYC = T_SUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int T_TEMP_MS = 25;
  localparam int TEMP_CYC = T_TEMP_MS * 1000000 / CLK_PERIOD_NS;

  localparam int ADC_W = 12;
  localparam int MAX_STAGES = 4;
  localparam logic [3:0] EXTRA_CH = 4'h4;

  localparam logic [3:0] SLOT_IOUT0 = 4'h2;
  localparam logic [3:0] SLOT_TEXT = 4'h6;
  localparam logic [3:0] SLOT_TINT = 4'h7;
  localparam logic [3:0] SLOT_VIN = 4'h8;
  localparam logic [3:0] SLOT_TRACK = 4'h9;
  localparam logic [3:0] SLOT_IIN = 4'hA;

  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_SHUT = 5'h02;
  localparam logic [4:0] REG_SEQ = 5'h03;
  localparam logic [4:0] REG_LIM_HI = 5'h04;
  localparam logic [4:0] REG_LIM_LO = 5'h08;
  localparam logic [4:0] REG_GAIN = 5'h0C;
  localparam logic [4:0] REG_AVG = 5'h14;

  localparam int CTRL_RAILS_LSB = 0;
  localparam int CTRL_STAGES_LSB = 2;
  localparam int CTRL_RUN_BIT = 5;
  localparam int CTRL_MAP_LSB = 6;
  localparam int CTRL_ACT_LSB = 10;
  localparam logic [31:0] CTRL_MASK = 32'h0003_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0011;

  localparam int ST_FLT_HI_LSB = 0;
  localparam int ST_WARN_LSB = 4;
  localparam int ST_FLT_LO_LSB = 8;
  localparam int ST_EXT_LSB = 12;
  localparam int ST_CMP_LSB = 16;
  localparam int STATUS_W = 20;

  localparam logic [31:0] LIM_HI_RESET = 32'hFFFF_FFFF;
  localparam logic [15:0] LIM_LO_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h0100;
  localparam int GAIN_SHIFT = 8;

  localparam logic [1:0] ACT_LOG = 2'h0;
  localparam logic [1:0] ACT_RAIL = 2'h1;

  typedef enum logic [1:0] {
    CL_VOUT = 2'h0,
    CL_IOUT = 2'h1,
    CL_SUP = 2'h2,
    CL_TEMP = 2'h3
  } check_class_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_READ = 2'b01,
    MS_WAIT = 2'b11,
    MS_CHECK = 2'b10
  } mon_state_t;

endpackage : adc_monitor_pkg

// *** verilog/result_store.sv ***
`timescale 1ns/10ps
`default_nettype none
module result_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
    $error("result_store: unsupported size");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : result_store
`default_nettype wire

// *** verilog/adc_monitor.sv ***
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module adc_monitor
  import adc_monitor_pkg::*;
#(
  parameter int VOUT_CYC_P = VOUT_CYC,
  parameter int SUP_CYC_P = SUP_CYC,
  parameter int TEMP_CYC_P = TEMP_CYC,
  parameter int FILT_SHIFT = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic device_reset_low,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic temp_mux_sel0,
  input wire logic adc_valid,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic ext_fault_in_1a,
  input wire logic ext_fault_in_1b,
  input wire logic ext_fault_in_2a,
  input wire logic ext_fault_in_3a,
  input wire logic [3:0] cmp_trip,
  input wire logic [3:0] pwm_in,
  input wire logic [3:0] sre_in,
  output logic [3:0] pulse_width_out,
  output logic [3:0] sync_rectifier_en,
  output logic ibal_update
);

  localparam int VW = $clog2(VOUT_CYC_P);
  localparam int SW = $clog2(SUP_CYC_P);
  localparam int TW = $clog2(TEMP_CYC_P);

  if (VOUT_CYC_P < 2 || SUP_CYC_P < 2 || TEMP_CYC_P < 2 || FILT_SHIFT < 1
      || FILT_SHIFT > 8) begin : g_bad_param
    $error("adc_monitor: unsupported parameter value");
  end

  // pins pass two flops; nothing reads sync1_reg but sync2_reg
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [3:0] ext_s;
  logic [3:0] cmp_s;
  logic rst;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end else begin
      sync1_reg <= {device_reset_low, cmp_trip, ext_fault_in_3a, ext_fault_in_2a,
                    ext_fault_in_1b, ext_fault_in_1a};
      sync2_reg <= sync1_reg;
    end
  end

  assign rst = srst | ~sync2_reg[8];
  assign ext_s = sync2_reg[3:0];
  // comparator n+1 belongs to stage index n (1a, 1b, 2a, 3a)
  assign cmp_s = sync2_reg[7:4];

  // configuration and status
  logic [31:0] ctrl_reg, ctrl_next;
  logic [STATUS_W-1:0] status_reg, status_next;
  logic [3:0] shut_reg, shut_next;
  logic [3:0][31:0] lim_hi_reg, lim_hi_next;
  logic [3:0][15:0] lim_lo_reg, lim_lo_next;
  logic [3:0][15:0] gain_reg, gain_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [STATUS_W-1:0] status_set;
  logic [3:0] shut_set;
  logic [11:0] mon_set;
  logic [3:0] mon_shut;
  logic [3:0] hw_shut;

  logic [1:0] rails_raw;
  logic [2:0] stages_raw;
  logic [1:0] rail_count;
  logic [2:0] stage_count;
  logic run;
  logic [3:0] rail_map;
  logic [3:0] en_mask;
  logic [3:0][15:0] avg_all;

  // sequencer
  logic [7:0] samp_cnt_reg, samp_cnt_next;
  logic [3:0] pos_reg, pos_next;
  logic [3:0] slot_reg, slot_next;
  logic [3:0] chan_reg, chan_next;
  logic start_reg, start_next;
  logic tmux_reg, tmux_next;
  logic [7:0] seq_cnt_reg, seq_cnt_next;
  logic [15:0] slot_ok_reg, slot_ok_next;
  logic [3:0] seq_len;
  logic samp_tick;

  assign rails_raw = ctrl_reg[CTRL_RAILS_LSB +: 2];
  assign stages_raw = ctrl_reg[CTRL_STAGES_LSB +: 3];
  // out-of-range counts are clamped into the supported set
  assign rail_count = (rails_raw == 2'h0) ? 2'h1 : ((rails_raw > 2'h2) ? 2'h2 : rails_raw);
  assign stage_count = (stages_raw == 3'h0) ? 3'h1
                     : ((stages_raw > 3'h4) ? 3'h4 : stages_raw);
  assign run = ctrl_reg[CTRL_RUN_BIT];
  assign rail_map = ctrl_reg[CTRL_MAP_LSB +: 4];
  assign en_mask = 4'(((5'h01 << stage_count) - 5'h01));
  assign seq_len = 4'({2'h0, rail_count}) + 4'({1'b0, stage_count}) + EXTRA_CH;

  function automatic logic [3:0] rail_mask(input logic r, input logic [3:0] map,
                                           input logic [3:0] en);
    rail_mask = (r ? map : ~map) & en;
  endfunction : rail_mask

  function automatic logic [3:0] slot_of(input logic [3:0] p, input logic [1:0] rc,
                                         input logic [2:0] sc, input logic sel);
    logic [3:0] k;
    k = p - {2'h0, rc} - {1'b0, sc};
    if (p < {2'h0, rc}) begin
      slot_of = p;
    end else if (p < {2'h0, rc} + {1'b0, sc}) begin
      slot_of = SLOT_IOUT0 + p - {2'h0, rc};
    end else begin
      case (k)
        4'h0: slot_of = SLOT_TEXT;
        4'h1: slot_of = SLOT_TINT;
        4'h2: slot_of = sel ? SLOT_IIN : SLOT_VIN;
        default: slot_of = SLOT_TRACK;
      endcase
    end
  endfunction : slot_of

  assign samp_tick = run && (samp_cnt_reg == 8'(SAMPLE_CYC - 1));

  always_comb begin
    samp_cnt_next = run ? (samp_tick ? 8'h00 : samp_cnt_reg + 8'h01) : 8'h00;
    pos_next = run ? pos_reg : 4'h0;
    slot_next = slot_reg;
    chan_next = chan_reg;
    start_next = 1'b0;
    tmux_next = tmux_reg;
    seq_cnt_next = seq_cnt_reg;
    slot_ok_next = slot_ok_reg;
    if (samp_tick) begin
      start_next = 1'b1;
      slot_next = slot_of(pos_reg, rail_count, stage_count, tmux_reg);
      chan_next = (slot_next == SLOT_IIN) ? SLOT_VIN : slot_next;
      if (pos_reg >= seq_len - 4'h1) begin
        pos_next = 4'h0;
        // flip the supply selection between sequences
        tmux_next = ~tmux_reg;
        seq_cnt_next = seq_cnt_reg + 8'h01;
      end else begin
        pos_next = pos_reg + 4'h1;
      end
    end
    if (adc_valid) begin
      slot_ok_next[slot_reg] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_reg <= 8'h00;
      pos_reg <= 4'h0;
      slot_reg <= 4'h0;
      chan_reg <= 4'h0;
      start_reg <= 1'b0;
      tmux_reg <= 1'b0;
      seq_cnt_reg <= 8'h00;
      slot_ok_reg <= 16'h0000;
    end else begin
      samp_cnt_reg <= samp_cnt_next;
      pos_reg <= pos_next;
      slot_reg <= slot_next;
      chan_reg <= chan_next;
      start_reg <= start_next;
      tmux_reg <= tmux_next;
      seq_cnt_reg <= seq_cnt_next;
      slot_ok_reg <= slot_ok_next;
    end
  end

  // current smoothing, one first-order average per stage
  for (genvar i = 0; i < MAX_STAGES; i++) begin : g_filt
    logic [15:0] avg_reg, avg_next;
    logic signed [16:0] diff;

    always_comb begin
      diff = $signed({1'b0, adc_data, 4'h0}) - $signed({1'b0, avg_reg});
      avg_next = avg_reg;
      if (adc_valid && slot_reg == SLOT_IOUT0 + 4'(i)) begin
        avg_next = 16'($signed({1'b0, avg_reg}) + (diff >>> FILT_SHIFT));
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        avg_reg <= 16'h0000;
      end else begin
        avg_reg <= avg_next;
      end
    end

    assign avg_all[i] = avg_reg;
  end

  // monitor, paced by its own timers and never by the sequencer
  logic [VW-1:0] vout_cnt_reg, vout_cnt_next;
  logic [SW-1:0] sup_cnt_reg, sup_cnt_next;
  logic [TW-1:0] temp_cnt_reg, temp_cnt_next;
  logic iout_div_reg, iout_div_next;
  logic [1:0] temp_div_reg, temp_div_next;
  logic [3:0] pend_reg, pend_next;
  logic [3:0] pend_clr;
  logic bal_reg, bal_next;
  mon_state_t mst_reg, mst_next;
  check_class_t cls_reg, cls_next;
  logic [2:0] idx_reg, idx_next;
  logic [15:0] val_reg, val_next;
  logic vout_tick, iout_tick, sup_tick, temp_base, temp_tick;
  logic [3:0] rd_addr;
  logic [ADC_W-1:0] rd_data;
  logic [ADC_W-1:0] raw;
  logic [27:0] prod;
  logic [2:0] item_cnt;
  logic item_ok;
  logic hi_f, lo_f;
  logic [1:0] act;

  assign vout_tick = vout_cnt_reg == VW'(VOUT_CYC_P - 1);
  assign iout_tick = vout_tick && ({1'b0, iout_div_reg} == rail_count - 2'h1);
  assign sup_tick = sup_cnt_reg == SW'(SUP_CYC_P - 1);
  assign temp_base = temp_cnt_reg == TW'(TEMP_CYC_P - 1);
  assign temp_tick = temp_base && ({1'b0, temp_div_reg} == stage_count - 3'h1);

  always_comb begin
    case (cls_reg)
      CL_VOUT: rd_addr = {3'h0, idx_reg[0]};
      CL_SUP: rd_addr = idx_reg[0] ? SLOT_IIN : SLOT_VIN;
      CL_TEMP: rd_addr = idx_reg[0] ? SLOT_TINT : SLOT_TEXT;
      default: rd_addr = SLOT_IOUT0 + {2'h0, idx_reg[1:0]};
    endcase
    case (cls_reg)
      CL_VOUT: item_cnt = {1'b0, rail_count};
      CL_IOUT: item_cnt = stage_count;
      default: item_cnt = 3'h2;
    endcase
    raw = (cls_reg == CL_IOUT) ? avg_all[idx_reg[1:0]][15:4] : rd_data;
    prod = 28'(raw) * 28'(gain_reg[cls_reg]);
    item_ok = (cls_reg == CL_IOUT) || slot_ok_reg[rd_addr];
    hi_f = val_reg > lim_hi_reg[cls_reg][15:0];
    lo_f = val_reg < lim_lo_reg[cls_reg];
    act = ctrl_reg[CTRL_ACT_LSB + 2 * cls_reg +: 2];
  end

  always_comb begin
    vout_cnt_next = vout_tick ? '0 : vout_cnt_reg + VW'(1);
    sup_cnt_next = sup_tick ? '0 : sup_cnt_reg + SW'(1);
    temp_cnt_next = temp_base ? '0 : temp_cnt_reg + TW'(1);
    iout_div_next = vout_tick ? (iout_tick ? 1'b0 : ~iout_div_reg) : iout_div_reg;
    temp_div_next = temp_base ? (temp_tick ? 2'h0 : temp_div_reg + 2'h1) : temp_div_reg;
    bal_next = sup_tick && run;
    mst_next = mst_reg;
    cls_next = cls_reg;
    idx_next = idx_reg;
    val_next = val_reg;
    pend_clr = 4'h0;
    mon_set = 12'h000;
    mon_shut = 4'h0;
    case (mst_reg)
      MS_IDLE: begin
        if (|pend_reg) begin
          cls_next = pend_reg[0] ? CL_VOUT : (pend_reg[1] ? CL_IOUT
                   : (pend_reg[2] ? CL_SUP : CL_TEMP));
          idx_next = 3'h0;
          mst_next = MS_READ;
        end
      end
      MS_READ: begin
        mst_next = MS_WAIT;
      end
      MS_WAIT: begin
        val_next = prod[GAIN_SHIFT +: 16];
        mst_next = MS_CHECK;
      end
      MS_CHECK: begin
        if (item_ok) begin
          mon_set[ST_FLT_HI_LSB + cls_reg] = hi_f;
          mon_set[ST_WARN_LSB + cls_reg] = val_reg > lim_hi_reg[cls_reg][31:16];
          mon_set[ST_FLT_LO_LSB + cls_reg] = lo_f;
          if ((hi_f || lo_f) && act != ACT_LOG) begin
            // per-rail action narrows vout and iout faults to the owning rail; all else stops every stage
            if (act == ACT_RAIL && cls_reg == CL_VOUT) begin
              mon_shut = rail_mask(idx_reg[0], rail_map, en_mask);
            end else if (act == ACT_RAIL && cls_reg == CL_IOUT) begin
              mon_shut = rail_mask(rail_map[idx_reg[1:0]], rail_map, en_mask);
            end else begin
              mon_shut = en_mask;
            end
          end
        end
        if (idx_reg >= item_cnt - 3'h1) begin
          pend_clr[cls_reg] = 1'b1;
          mst_next = MS_IDLE;
        end else begin
          idx_next = idx_reg + 3'h1;
          mst_next = MS_READ;
        end
      end
      default: begin
        mst_next = MS_IDLE;
      end
    endcase
    pend_next = (pend_reg & ~pend_clr) | ({temp_tick, sup_tick, iout_tick, vout_tick} & {4{run}});
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vout_cnt_reg <= '0;
      sup_cnt_reg <= '0;
      temp_cnt_reg <= '0;
      iout_div_reg <= 1'b0;
      temp_div_reg <= 2'h0;
      bal_reg <= 1'b0;
      pend_reg <= 4'h0;
      mst_reg <= MS_IDLE;
      cls_reg <= CL_VOUT;
      idx_reg <= 3'h0;
      val_reg <= 16'h0000;
    end else begin
      vout_cnt_reg <= vout_cnt_next;
      sup_cnt_reg <= sup_cnt_next;
      temp_cnt_reg <= temp_cnt_next;
      iout_div_reg <= iout_div_next;
      temp_div_reg <= temp_div_next;
      bal_reg <= bal_next;
      pend_reg <= pend_next;
      mst_reg <= mst_next;
      cls_reg <= cls_next;
      idx_reg <= idx_next;
      val_reg <= val_next;
    end
  end

  result_store #(
    .WIDTH(ADC_W),
    .DEPTH(16)
  ) u_store (
    .clk(clk),
    .wr_en(adc_valid),
    .wr_addr(slot_reg),
    .wr_data(adc_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // hardware fault paths: three clocks from pin to output
  always_comb begin
    hw_shut = ext_s;
    for (int i = 0; i < MAX_STAGES; i++) begin
      if (cmp_s[i]) begin
        hw_shut = hw_shut | (4'h1 << i);
        hw_shut = hw_shut | rail_mask(rail_map[i], rail_map, en_mask);
      end
    end
  end

  assign shut_set = hw_shut | mon_shut;
  assign status_set = {cmp_s, ext_s, mon_set};

  always_comb begin
    ctrl_next = ctrl_reg;
    lim_hi_next = lim_hi_reg;
    lim_lo_next = lim_lo_reg;
    gain_next = gain_reg;
    status_next = status_reg;
    shut_next = shut_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr[4:2])
        REG_CTRL[4:2]: begin
          if (reg_addr == REG_CTRL) begin
            ctrl_next = reg_wdata & CTRL_MASK;
          end else if (reg_addr == REG_STATUS) begin
            status_next = status_reg & ~reg_wdata[STATUS_W-1:0];
          end else if (reg_addr == REG_SHUT) begin
            shut_next = shut_reg & ~reg_wdata[3:0];
          end
        end
        REG_LIM_HI[4:2]: lim_hi_next[reg_addr[1:0]] = reg_wdata;
        REG_LIM_LO[4:2]: lim_lo_next[reg_addr[1:0]] = reg_wdata[15:0];
        REG_GAIN[4:2]: gain_next[reg_addr[1:0]] = reg_wdata[15:0];
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    status_next = status_next | status_set;
    shut_next = shut_next | shut_set;
    if (reg_rd) begin
      case (reg_addr[4:2])
        REG_CTRL[4:2]: begin
          case (reg_addr[1:0])
            REG_CTRL[1:0]: rdata_next = ctrl_reg;
            REG_STATUS[1:0]: rdata_next = 32'(status_reg);
            REG_SHUT[1:0]: rdata_next = {28'h0, shut_reg};
            default: rdata_next = {19'h0, tmux_reg, pos_reg, seq_cnt_reg};
          endcase
        end
        REG_LIM_HI[4:2]: rdata_next = lim_hi_reg[reg_addr[1:0]];
        REG_LIM_LO[4:2]: rdata_next = {16'h0, lim_lo_reg[reg_addr[1:0]]};
        REG_GAIN[4:2]: rdata_next = {16'h0, gain_reg[reg_addr[1:0]]};
        REG_AVG[4:2]: rdata_next = {16'h0, avg_all[reg_addr[1:0]]};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      lim_hi_reg <= {4{LIM_HI_RESET}};
      lim_lo_reg <= {4{LIM_LO_RESET}};
      gain_reg <= {4{GAIN_RESET}};
      status_reg <= '0;
      shut_reg <= 4'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      lim_hi_reg <= lim_hi_next;
      lim_lo_reg <= lim_lo_next;
      gain_reg <= gain_next;
      status_reg <= status_next;
      shut_reg <= shut_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs gated by the same-cycle set term, saving a clock on a fault
  logic [3:0] pwm_reg, sre_reg;
  logic [3:0] pwm_next, sre_next;

  always_comb begin
    pwm_next = pwm_in & ~(shut_reg | shut_set) & en_mask;
    sre_next = sre_in & ~(shut_reg | shut_set) & en_mask;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_reg <= 4'h0;
      sre_reg <= 4'h0;
    end else begin
      pwm_reg <= pwm_next;
      sre_reg <= sre_next;
    end
  end

  assign pulse_width_out = pwm_reg;
  assign sync_rectifier_en = sre_reg;
  assign reg_rdata = rdata_reg;
  assign adc_start = start_reg;
  assign adc_channel = chan_reg;
  assign temp_mux_sel0 = tmux_reg;
  assign ibal_update = bal_reg;

endmodule : adc_monitor
`default_nettype wire

// *** test/adc_monitor_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_monitor_props
  import adc_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic device_reset_low,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  input wire logic temp_mux_sel0,
  input wire logic ext_fault_in_1a,
  input wire logic [3:0] cmp_trip,
  input wire logic [3:0] pwm_in,
  input wire logic [3:0] sre_in,
  input wire logic [3:0] pulse_width_out,
  input wire logic [3:0] sync_rectifier_en
);
  default clocking @(posedge clk); endclocking
  // the pin reset is quiet only while low; outputs clear three edges later
  default disable iff (srst || !device_reset_low);
  property p_ext;
    ext_fault_in_1a [*3] |=> !pulse_width_out[0] && !sync_rectifier_en[0];
  endproperty
  a_ext: assert property (p_ext) else $error("ext fault did not stop stage");
  property p_cmp;
    cmp_trip[1] [*3] |=> !pulse_width_out[1] && !sync_rectifier_en[1];
  endproperty
  a_cmp: assert property (p_cmp) else $error("trip did not stop stage");
  property p_pw_gate;
    pulse_width_out[2] |-> $past(pwm_in[2]);
  endproperty
  a_pw_gate: assert property (p_pw_gate) else $error("pulse out without source");
  property p_sre_gate;
    sync_rectifier_en[3] |-> $past(sre_in[3]);
  endproperty
  a_sre_gate: assert property (p_sre_gate) else $error("rectifier on without source");
  property p_rst;
    disable iff (srst) !device_reset_low [*3] |=>
      pulse_width_out == 4'h0 && sync_rectifier_en == 4'h0 && !adc_start;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in pin reset");
  property p_gap;
    adc_start |=> !adc_start [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("starts too close");
  property p_pace;
    adc_start |-> ##154 adc_start;
  endproperty
  a_pace: assert property (p_pace) else $error("sample pacing wrong");
  property p_mux;
    $changed(temp_mux_sel0) |-> adc_start && adc_channel == SLOT_TRACK;
  endproperty
  a_mux: assert property (p_mux) else $error("supply select moved off track");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  c_ext: cover property (ext_fault_in_1a ##3 !pulse_width_out[0]);
  c_cmp: cover property (cmp_trip[1] ##3 !pulse_width_out[1]);
  c_track: cover property (adc_start && adc_channel == SLOT_TRACK);
endmodule : adc_monitor_props
bind adc_monitor adc_monitor_props u_adc_monitor_props (.clk, .srst, .device_reset_low,
  .reg_rd, .reg_rdata, .adc_start, .adc_channel, .temp_mux_sel0, .ext_fault_in_1a,
  .cmp_trip, .pwm_in, .sre_in, .pulse_width_out, .sync_rectifier_en);
`default_nettype wire

// *** test/sense_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sense_model
  import adc_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  input wire logic slow,
  input wire logic [ADC_W-1:0] vout_level,
  output logic adc_valid,
  output logic [ADC_W-1:0] adc_data
);
  // slow answers still land before the next start, 154 cycles on
  int wait_cnt = 0;
  logic [3:0] ch = 4'h0;
  always @(posedge clk) begin
    adc_valid <= 1'b0;
    adc_data <= 12'(wait_cnt);
    if (adc_start) begin
      ch <= adc_channel;
      wait_cnt <= slow ? 120 : 2;
    end else if (wait_cnt == 1) begin
      adc_valid <= 1'b1;
      adc_data <= (ch == 4'h0) ? vout_level : 12'h100;
    end
    if (!adc_start && wait_cnt != 0) wait_cnt <= wait_cnt - 1;
  end
endmodule : sense_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import adc_monitor_pkg::*;
  localparam int SUP_P = 200;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic device_reset_low = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [3:0] ext_in = 4'h0;
  logic [3:0] cmp_trip = 4'h0;
  logic [3:0] pwm_in = 4'hF;
  logic [3:0] sre_in = 4'hF;
  logic [ADC_W-1:0] vout_level = 12'h100;
  logic [31:0] reg_rdata;
  logic adc_start, temp_mux_sel0, adc_valid, ibal_update;
  logic [3:0] adc_channel, pulse_width_out, sync_rectifier_en;
  logic [ADC_W-1:0] adc_data;
  int num_errors = 0;
  int total_checks = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  adc_monitor #(.VOUT_CYC_P(40), .SUP_CYC_P(SUP_P), .TEMP_CYC_P(400)) u_adc_monitor (.clk,
    .srst, .device_reset_low, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .adc_start, .adc_channel, .temp_mux_sel0, .adc_valid, .adc_data,
    .ext_fault_in_1a(ext_in[0]), .ext_fault_in_1b(ext_in[1]), .ext_fault_in_2a(ext_in[2]),
    .ext_fault_in_3a(ext_in[3]), .cmp_trip, .pwm_in, .sre_in, .pulse_width_out,
    .sync_rectifier_en, .ibal_update);
  sense_model u_sense_model (.clk, .adc_start, .adc_channel, .slow, .vout_level,
    .adc_valid, .adc_data);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic give_up();
    num_errors++;
    stop_test();
  endtask : give_up
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic wait_start();
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (adc_start === 1'b1) return;
    end
    give_up();
  endtask : wait_start
  task automatic wait_pw(input logic [3:0] e);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (pulse_width_out === e) return;
    end
    give_up();
  endtask : wait_pw
  function automatic logic [3:0] exp_ch(input int k, input int r, input int s);
    if (k < r) return 4'(k);
    if (k < r + s) return 4'(SLOT_IOUT0 + k - r);
    return 4'(SLOT_TEXT + k - r - s);
  endfunction : exp_ch
  task automatic t_regs();
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_LIM_HI, LIM_HI_RESET);
    rd(REG_GAIN, {16'h0, GAIN_RESET});
    rd(REG_SEQ, 32'h0);
    rd(REG_AVG, 32'h0);
    wr(5'h1F, 32'h1234_5678);
    rd(5'h1F, 32'h0);
  endtask : t_regs
  task automatic t_seq(input logic [31:0] ctrl, input int r, input int s, input logic sl);
    logic mux;
    @(posedge clk) slow <= sl;
    wr(REG_CTRL, ctrl);
    for (int k = 0; k < 12; k++) begin
      wait_start();
      if (adc_channel === SLOT_TRACK) break;
    end
    mux = temp_mux_sel0;
    for (int k = 0; k < r + s + 4; k++) begin
      wait_start();
      chk(adc_channel, exp_ch(k, r, s));
    end
    chk(temp_mux_sel0, !mux);
  endtask : t_seq
  task automatic t_ext();
    @(posedge clk) ext_in <= 4'h1;
    repeat (3) @(posedge clk);
    #1 chk({sync_rectifier_en, pulse_width_out}, 8'hEE);
    wr(REG_SHUT, 32'h1);
    rd(REG_SHUT, 32'h1);
    rd(REG_STATUS, 32'h1000);
    @(posedge clk) ext_in <= 4'h0;
    repeat (3) @(posedge clk);
    wr(REG_STATUS, 32'h1000);
    wr(REG_SHUT, 32'h1);
    rd(REG_STATUS, 32'h0);
    wait_pw(4'hF);
  endtask : t_ext
  task automatic t_cmp();
    @(posedge clk) cmp_trip <= 4'h2;
    wait_pw(4'h5);
    chk(sync_rectifier_en, 4'h5);
    rd(REG_STATUS, 32'h0002_0000);
    @(posedge clk) cmp_trip <= 4'h0;
    repeat (3) @(posedge clk);
    wr(REG_STATUS, 32'h0002_0000);
    wr(REG_SHUT, 32'hF);
    wait_pw(4'hF);
    @(posedge clk) pwm_in <= 4'h3;
    sre_in <= 4'h7;
    repeat (2) @(posedge clk);
    #1 chk({sync_rectifier_en, pulse_width_out}, 8'h73);
    @(posedge clk) pwm_in <= 4'hF;
    sre_in <= 4'hF;
    wait_pw(4'hF);
  endtask : t_cmp
  task automatic t_vout();
    wr(REG_LIM_HI, 32'h0700_0800);
    @(posedge clk) vout_level <= 12'h900;
    wait_pw(4'hA);
    rd(REG_STATUS, 32'h11);
    @(posedge clk) vout_level <= 12'h100;
  endtask : t_vout
  task automatic t_ibal();
    int n;
    wait_pw(4'hA);
    for (n = 0; n < 400 && ibal_update !== 1'b1; n++) @(negedge clk);
    for (n = 1; n < 400; n++) begin
      @(negedge clk);
      if (ibal_update === 1'b1) break;
    end
    chk(n, SUP_P);
  endtask : t_ibal
  task automatic t_pin();
    @(posedge clk) device_reset_low <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({sync_rectifier_en, pulse_width_out}, 8'h00);
    @(posedge clk) device_reset_low <= 1'b1;
    repeat (4) @(posedge clk);
    rd(REG_CTRL, CTRL_RESET);
  endtask : t_pin
  task automatic t_low();
    wr(REG_CTRL, 32'h86B2);
    wr(REG_LIM_LO + 5'h02, 32'h200);
    wait_pw(4'h0);
    rd(REG_STATUS, 32'h400);
  endtask : t_low
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_seq(32'h25, 1, 1, 1'b1);
    t_seq(32'h6B2, 2, 4, 1'b0);
    t_ext();
    t_cmp();
    t_vout();
    t_ibal();
    t_pin();
    t_low();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
